// ==== hdl/serial_shift_interface.sv ====
// serial shift interface with an axi4-lite register port
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "serial_shift_consts.svh"
module serial_shift_interface (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timerCompareMatch,
  input wire logic serialClockPinIn,
  input wire logic serialDataInPin,
  output serial_shift_pkg::pins_s pins,
  output logic startInterrupt,
  output logic overflowInterrupt,
  output logic startWakeup,
  output logic overflowWakeup
);
  import serial_shift_pkg::*;

  // *****************************************************************
  // *****************************************************************

  // *****************************************************************
  // input synchronisers
  // *****************************************************************
  logic [2:0] sckSync_q;
  logic [2:0] sdaSync_q;
  logic sckLevel_q;
  logic sdaLevel_q;
  logic dataInPrev_q;
  // no reset: the level flops follow these stages through reset instead
  always_ff @(posedge clock) begin
    sckSync_q <= {sckSync_q[1:0], serialClockPinIn};
    sdaSync_q <= {sdaSync_q[1:0], serialDataInPin};
  end
  // a change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // idle level of the pins is unknown, so track them: no false edge at release
      sckLevel_q <= sckSync_q[2];
      sdaLevel_q <= sdaSync_q[2];
      dataInPrev_q <= 1'b0;
    end else begin
      if (sckSync_q[1] == sckSync_q[2]) sckLevel_q <= sckSync_q[2];
      if (sdaSync_q[1] == sdaSync_q[2]) sdaLevel_q <= sdaSync_q[2];
      dataInPrev_q <= sdaLevel_q;
    end
  end
  logic sckRise;
  logic sckFall;
  logic sckChange;
  logic sdaFall;
  logic sdaRise;
  assign sckChange = (sckSync_q[1] == sckSync_q[2]) && (sckSync_q[2] != sckLevel_q);
  assign sckRise = sckChange && sckSync_q[2];
  assign sckFall = sckChange && !sckSync_q[2];
  assign sdaRise = (sdaSync_q[1] == sdaSync_q[2]) && sdaSync_q[2] && !sdaLevel_q;
  assign sdaFall = (sdaSync_q[1] == sdaSync_q[2]) && !sdaSync_q[2] && sdaLevel_q;

  // *****************************************************************
  // axi4-lite slave
  // *****************************************************************
  logic [11:0] awAddr_q;
  logic awHeld_q;
  logic [7:0] wData_q;
  logic wHeld_q;
  logic wrFire;
  logic wrKnown;
  logic rdFire;
  assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSI_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wrCtrl;
  logic wrStatus;
  logic wrData;
  logic wrDir;
  always_comb begin
    wrCtrl = 1'b0;
    wrStatus = 1'b0;
    wrData = 1'b0;
    wrDir = 1'b0;
    if (awAddr_q == `SSI_CTRL_ADDR) wrCtrl = wrFire;
    else if (awAddr_q == `SSI_STATUS_ADDR) wrStatus = wrFire;
    else if (awAddr_q == `SSI_DATA_ADDR) wrData = wrFire;
    else if (awAddr_q == `SSI_DIR_ADDR) wrDir = wrFire;
  end
  assign wrKnown = (awAddr_q == `SSI_CTRL_ADDR) || (awAddr_q == `SSI_STATUS_ADDR) ||
    (awAddr_q == `SSI_DATA_ADDR) || (awAddr_q == `SSI_DIR_ADDR) || (awAddr_q == `SSI_BUFFER_ADDR);

  // *****************************************************************
  // control, direction and strobes
  // *****************************************************************
  control_s ctrl_q;
  logic clockStrobeBit_q;
  logic dataDir_q;
  logic clockDir_q;
  logic strobeWrite;
  logic toggleWrite;
  assign strobeWrite = wrCtrl && wData_q[`SSI_BIT_STROBE];
  assign toggleWrite = wrCtrl && wData_q[`SSI_BIT_TOGGLE];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      clockStrobeBit_q <= 1'b0;
      dataDir_q <= 1'b0;
      clockDir_q <= 1'b0;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= control_s'(wData_q[7:2]);
        clockStrobeBit_q <= wData_q[`SSI_BIT_STROBE];
      end
      if (wrDir) begin
        dataDir_q <= wData_q[0];
        clockDir_q <= wData_q[1];
      end
    end
  end

  // *****************************************************************
  // clock selection
  // *****************************************************************
  logic shiftTick;
  logic countTick;
  logic isExternal;
  assign isExternal = ctrl_q.clockSourceSelect[1];
  always_comb begin
    shiftTick = 1'b0;
    countTick = 1'b0;
    case (ctrl_q.clockSourceSelect)
      2'b00: begin
        shiftTick = strobeWrite;
        countTick = strobeWrite;
      end
      2'b01: begin
        shiftTick = timerCompareMatch;
        countTick = timerCompareMatch;
      end
      default: begin
        // external pin clocks even with wire mode off
        shiftTick = ctrl_q.clockSourceSelect[0] ? sckFall : sckRise;
        countTick = clockStrobeBit_q ? toggleWrite : sckChange;
      end
    endcase
  end

  // *****************************************************************
  // shift data, counter, buffer
  // *****************************************************************
  logic [7:0] shiftData_q;
  logic [7:0] buffer_q;
  logic [3:0] count_q;
  logic wrap;
  assign wrap = countTick && !wrStatus && (count_q == `SSI_CNT_MAX);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shiftData_q <= `SSI_RESET_BYTE;
    end else if (wrData) begin
      shiftData_q <= wData_q;
    end else if (shiftTick) begin
      // strobe uses the bit sampled a cycle earlier
      shiftData_q <= {shiftData_q[6:0], dataInPrev_q};
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_q <= 4'h0;
    end else if (wrStatus) begin
      count_q <= wData_q[3:0];
    end else if (countTick) begin
      count_q <= count_q + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buffer_q <= `SSI_RESET_BYTE;
    end else if (wrap) begin
      // buffer takes the byte including the final shift
      buffer_q <= shiftTick && !wrData ? {shiftData_q[6:0], dataInPrev_q} : shiftData_q;
    end
  end

  // *****************************************************************
  // start, stop and overflow flags
  // *****************************************************************
  logic startFlag_q;
  logic overflowFlag_q;
  logic stopFlag_q;
  logic twoWire;
  logic startEvent;
  logic stopEvent;
  assign twoWire = ctrl_q.wireModeSelect[1];
  assign startEvent = twoWire ? (sdaFall && sckLevel_q) : sckChange;
  assign stopEvent = twoWire && sdaRise && sckLevel_q;
  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      startFlag_q <= 1'b0;
      overflowFlag_q <= 1'b0;
      stopFlag_q <= 1'b0;
    end else begin
      if (startEvent) startFlag_q <= 1'b1;
      else if (wrStatus && wData_q[`SSI_BIT_START]) startFlag_q <= 1'b0;
      if (wrap) overflowFlag_q <= 1'b1;
      else if (wrStatus && wData_q[`SSI_BIT_OVF]) overflowFlag_q <= 1'b0;
      if (stopEvent) stopFlag_q <= 1'b1;
      else if (wrStatus && wData_q[`SSI_BIT_STOP]) stopFlag_q <= 1'b0;
    end
  end
  // interrupt lines carry the flag ANDed with its enable bit; global enable sits in the cpu core
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      startInterrupt <= 1'b0;
      overflowInterrupt <= 1'b0;
      startWakeup <= 1'b0;
      overflowWakeup <= 1'b0;
    end else begin
      startInterrupt <= startFlag_q && ctrl_q.startInterruptEnable;
      overflowInterrupt <= overflowFlag_q && ctrl_q.overflowInterruptEnable;
      startWakeup <= startFlag_q && ctrl_q.startInterruptEnable;
      overflowWakeup <= overflowFlag_q && ctrl_q.overflowInterruptEnable;
    end
  end

  // *****************************************************************
  // output latch and pins
  // *****************************************************************
  logic clockPort_q;
  logic dataLatch_q;
  logic latchOpen;
  logic nextMsb;
  logic holdLow;
  always_comb begin
    nextMsb = shiftData_q[7];
    if (wrData) nextMsb = wData_q[7];
    else if (shiftTick) nextMsb = shiftData_q[6];
  end
  // external: open in the half-cycle before the sampling edge, shut from that edge on
  assign latchOpen = !isExternal || (sckLevel_q == ctrl_q.clockSourceSelect[0] && !shiftTick);
  assign holdLow = twoWire && ((startFlag_q && clockDir_q) ||
    (ctrl_q.wireModeSelect == 2'(WIRE_TWO_HOLD) && overflowFlag_q));
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clockPort_q <= 1'b0;
      dataLatch_q <= 1'b0;
    end else begin
      if (toggleWrite) clockPort_q <= !clockPort_q;
      if (latchOpen) dataLatch_q <= nextMsb;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins.dataOut <= twoWire ? 1'b0 : dataLatch_q;
      pins.dataOutEn <= ctrl_q.wireModeSelect == 2'(WIRE_OFF) ? 1'b0 :
        (twoWire ? dataDir_q && !dataLatch_q : dataDir_q);
      pins.clockOut <= twoWire ? 1'b0 : clockPort_q;
      pins.clockOutEn <= twoWire ? clockDir_q && (holdLow || !clockPort_q) : clockDir_q;
    end
  end

  // *****************************************************************
  // read path
  // *****************************************************************
  logic [7:0] rdByte;
  logic rdKnown;
  logic collision;
  assign collision = shiftData_q[7] != sdaLevel_q;
  always_comb begin
    rdByte = 8'h00;
    rdKnown = 1'b1;
    if (s_axi_araddr == `SSI_CTRL_ADDR) rdByte = {ctrl_q, 2'b00};
    else if (s_axi_araddr == `SSI_STATUS_ADDR) rdByte = {startFlag_q, overflowFlag_q, stopFlag_q, collision, count_q};
    else if (s_axi_araddr == `SSI_DATA_ADDR) rdByte = shiftData_q;
    else if (s_axi_araddr == `SSI_BUFFER_ADDR) rdByte = buffer_q;
    else if (s_axi_araddr == `SSI_DIR_ADDR) rdByte = {6'h00, clockDir_q, dataDir_q};
    else rdKnown = 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSI_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdKnown ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // *****************************************************************
  // assertions
  // *****************************************************************
  a_idle_no_clock: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl_q.clockSourceSelect == 2'b00 && !strobeWrite && !wrStatus) |=> $stable(count_q))
    else $error("counter moved with no clock source");
  a_timer_counts: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl_q.clockSourceSelect == 2'b01 && timerCompareMatch && !wrStatus) |=> count_q == $past(count_q) + 4'h1)
    else $error("timer match did not step counter");
  a_strobe_shift: assert property (@(posedge clock) disable iff (!rst_n)
    (strobeWrite && ctrl_q.clockSourceSelect == 2'b00 && !wrData) |=> shiftData_q == {$past(shiftData_q[6:0]), $past(dataInPrev_q)})
    else $error("strobe shift wrong");
  a_write_beats_shift: assert property (@(posedge clock) disable iff (!rst_n)
    wrData |=> shiftData_q == $past(wData_q))
    else $error("written data lost to shift");
  a_wrap_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
    wrap |=> overflowFlag_q && count_q == 4'h0)
    else $error("wrap did not set overflow");
  a_toggle_inverts: assert property (@(posedge clock) disable iff (!rst_n)
    toggleWrite |=> clockPort_q != $past(clockPort_q))
    else $error("toggle did not invert clock port");
  a_start_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (startFlag_q && !(wrStatus && wData_q[`SSI_BIT_START])) |=> startFlag_q)
    else $error("start flag dropped without clear");
  a_strobe_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (rdFire && s_axi_araddr == `SSI_CTRL_ADDR) |=> s_axi_rdata[1:0] == 2'b00)
    else $error("strobe bits read nonzero");
endmodule : serial_shift_interface

// ==== hdl/serial_shift_consts.svh ====
// register offsets, field positions and reset values of the serial shift block
`ifndef SERIAL_SHIFT_CONSTS_SVH
`define SERIAL_SHIFT_CONSTS_SVH
`define SSI_CTRL_ADDR 12'h028
`define SSI_STATUS_ADDR 12'h0ac
`define SSI_DATA_ADDR 12'h030
`define SSI_BUFFER_ADDR 12'h034
`define SSI_DIR_ADDR 12'h038
`define SSI_STATUS_INDEX 8'h2b
`define SSI_BIT_START 7
`define SSI_BIT_OVF 6
`define SSI_BIT_STOP 5
`define SSI_BIT_COLL 4
`define SSI_BIT_SIE 7
`define SSI_BIT_OIE 6
`define SSI_BIT_STROBE 1
`define SSI_BIT_TOGGLE 0
`define SSI_RESET_BYTE 8'h00
`define SSI_CNT_MAX 4'hf
`define SSI_RESP_OKAY 2'b00
`define SSI_RESP_SLVERR 2'b10
`endif

// ==== hdl/serial_shift_pkg.sv ====
// types shared by the serial shift block
package serial_shift_pkg;
  typedef enum logic [1:0] {WIRE_OFF, WIRE_THREE, WIRE_TWO, WIRE_TWO_HOLD} wire_mode_e;
  typedef struct packed {
    logic startInterruptEnable;
    logic overflowInterruptEnable;
    logic [1:0] wireModeSelect;
    logic [1:0] clockSourceSelect;
  } control_s;
  typedef struct packed {
    logic dataOut;
    logic dataOutEn;
    logic clockOut;
    logic clockOutEn;
  } pins_s;
endpackage : serial_shift_pkg

// ==== test/serial_partner.sv ====
// model of the external serial device on the link clock and data pins
`timescale 1ns/1ps
module serial_partner (
  input wire logic dataOut,
  output logic linkClock,
  output logic linkData
);
  logic [7:0] rxByte;
  initial begin
    linkClock = 1'b0;
    linkData = 1'b1;
    rxByte = 8'h00;
  end
  // ****************************************
  // frames
  // ****************************************
  // 64 ns link period, offset so edges never sit on the system clock edge
  task automatic send_byte(input logic [7:0] b);
    #3;
    for (int i = 7; i >= 0; i--) begin
      linkData = b[i];
      #32 linkClock = 1'b1;
      // taken late in the high phase: output must not move after the sampling edge
      #31 rxByte = {rxByte[6:0], dataOut};
      #1 linkClock = 1'b0;
    end
    // released data line shows the inverse, never a stale bit
    linkData = ~linkData;
  endtask : send_byte
  // clock stands still high while the data line falls and then rises
  task automatic start_stop();
    #3 linkData = 1'b1;
    #32 linkClock = 1'b1;
    #32 linkData = 1'b0;
    #32 linkData = 1'b1;
    #32 linkClock = 1'b0;
  endtask : start_stop
endmodule : serial_partner

// ==== test/serial_shift_interface_bench.sv ====
// register-level bench of the serial shift interface
`timescale 1ns/1ps
`include "serial_shift_consts.svh"
module serial_shift_interface_bench;
  import serial_shift_pkg::*;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, timerMatch, linkClock, linkData;
  logic startIrq, overflowIrq, startWake, overflowWake, c;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  pins_s pins;
  int badCount = 0;
  int checksDone = 0;
  int cycles = 0;
  serial_shift_interface i_serial_shift_interface (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerCompareMatch(timerMatch), .serialClockPinIn(linkClock), .serialDataInPin(linkData),
    .pins(pins), .startInterrupt(startIrq), .overflowInterrupt(overflowIrq),
    .startWakeup(startWake), .overflowWakeup(overflowWake)
  );
  serial_partner i_serial_partner (
    .dataOut(pins.dataOut),
    .linkClock(linkClock),
    .linkData(linkData)
  );
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic completeRun();
    $display("mismatches %0d, comparisons %0d", badCount, checksDone);
    if (badCount == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : completeRun
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("Error at %0t ns: got %h, wanted %h", $time, g, e);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  // address and data offered together, each dropped when its own ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clock);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(got & m, e);
  endtask : rdChk
  // a hang is counted as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      completeRun();
    end
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, timerMatch} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    idle(10);
    rst_n <= 1'b1;
    idle(2);
    rdChk(`SSI_STATUS_ADDR, 32'hffffffef, 32'h00000000);
    rd(12'h0f0);
    check(got, 32'h00000000);
    check({30'h0, resp}, {30'h0, `SSI_RESP_SLVERR});
    wr(12'h0f4, 8'h55);
    check({30'h0, resp}, {30'h0, `SSI_RESP_SLVERR});
    // software strobe: shift in the idle-high data line
    wr(`SSI_DIR_ADDR, 8'h03);
    wr(`SSI_STATUS_ADDR, 8'h00);
    wr(`SSI_DATA_ADDR, 8'h81);
    wr(`SSI_CTRL_ADDR, 8'h10);
    idle(3);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'h81);
    check({30'h0, pins.dataOut, pins.dataOutEn}, 32'h3);
    wr(`SSI_CTRL_ADDR, 8'h12);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'h03);
    rdChk(`SSI_CTRL_ADDR, 32'h03, 32'h00);
    rdChk(`SSI_STATUS_ADDR, 32'h0f, 32'h01);
    check({31'h0, pins.dataOut}, 32'h0);
    // wrap from 15 to 0 completes a transfer
    wr(`SSI_STATUS_ADDR, 8'h0f);
    wr(`SSI_CTRL_ADDR, 8'h02);
    rdChk(`SSI_STATUS_ADDR, 32'h4f, 32'h40);
    rdChk(`SSI_BUFFER_ADDR, 32'hff, 32'h07);
    rdChk(`SSI_STATUS_ADDR, 32'h4f, 32'h40);
    wr(`SSI_STATUS_ADDR, 8'h40);
    rdChk(`SSI_STATUS_ADDR, 32'h4f, 32'h00);
    // timer compare match as the clock
    wr(`SSI_CTRL_ADDR, 8'h04);
    @(posedge clock);
    timerMatch <= 1'b1;
    @(posedge clock);
    timerMatch <= 1'b0;
    idle(3);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'h0f);
    rdChk(`SSI_STATUS_ADDR, 32'h0f, 32'h01);
    // toggle strobe on the clock output, then as the counter clock
    c = pins.clockOut;
    wr(`SSI_CTRL_ADDR, 8'h01);
    idle(3);
    check({30'h0, pins.clockOut, pins.clockOutEn}, {30'h0, ~c, 1'b1});
    wr(`SSI_STATUS_ADDR, 8'h00);
    wr(`SSI_CTRL_ADDR, 8'h08);
    wr(`SSI_CTRL_ADDR, 8'h0a);
    wr(`SSI_CTRL_ADDR, 8'h0b);
    rdChk(`SSI_STATUS_ADDR, 32'h0f, 32'h01);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'h0f);
    // external clock frame, three-wire, both interrupts enabled
    wr(`SSI_CTRL_ADDR, 8'hd8);
    wr(`SSI_STATUS_ADDR, 8'he0);
    wr(`SSI_DATA_ADDR, 8'h3c);
    i_serial_partner.send_byte(8'ha5);
    idle(8);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'ha5);
    rdChk(`SSI_BUFFER_ADDR, 32'hff, 32'ha5);
    rdChk(`SSI_STATUS_ADDR, 32'hef, 32'hc0);
    check({24'h0, i_serial_partner.rxByte}, 32'h3c);
    rdChk(`SSI_STATUS_ADDR, 32'h10, 32'h10);
    check({28'h0, startIrq, overflowIrq, startWake, overflowWake}, 32'hf);
    wr(`SSI_STATUS_ADDR, 8'hc0);
    idle(3);
    check({28'h0, startIrq, overflowIrq, startWake, overflowWake}, 32'h0);
    // inputs still work with the data output disabled (wire mode off)
    wr(`SSI_CTRL_ADDR, 8'h08);
    wr(`SSI_STATUS_ADDR, 8'he0);
    i_serial_partner.send_byte(8'h5a);
    idle(8);
    rdChk(`SSI_DATA_ADDR, 32'hff, 32'h5a);
    rdChk(`SSI_STATUS_ADDR, 32'h4f, 32'h40);
    // two-wire start and stop conditions
    wr(`SSI_CTRL_ADDR, 8'h28);
    wr(`SSI_STATUS_ADDR, 8'he0);
    i_serial_partner.start_stop();
    idle(8);
    rdChk(`SSI_STATUS_ADDR, 32'he0, 32'ha0);
    completeRun();
  end
endmodule : serial_shift_interface_bench
